// ---- rtl/mcx_exc_unit.sv ----
// Machine-check and packed-fp exception signalling unit
`include "mcx_consts.svh"
`default_nettype none
module mcx_exc_unit #(
   parameter int LANES = 4,
   parameter logic [7:0] UD_VECTOR = 8'h06
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic bus_init_error_pin_n,
   input wire logic bus_error_report_pin_n,
   input wire logic bus_check_pin_n,
   input wire logic int_err_valid,
   input wire logic [15:0] int_err_code,
   input wire logic [31:0] cur_ip,
   input wire logic [15:0] cur_cs,
   input wire logic cur_ip_related,
   input wire logic fp_op_valid,
   input wire logic fp_quad,
   input wire logic [LANES-1:0] fp_signalling_not_a_number,
   input wire logic [LANES-1:0] fp_quiet_not_a_number,
   input wire logic [LANES-1:0] fp_inv_other,
   input wire logic [LANES-1:0] fp_divz,
   input wire logic [LANES-1:0] fp_denorm,
   input wire logic [LANES-1:0] fp_ovf,
   input wire logic [LANES-1:0] fp_unf,
   input wire logic [LANES-1:0] fp_inex,
   output logic fault_valid,
   output logic [7:0] fault_vector,
   output logic fault_abort,
   output logic fault_push_code,
   output logic [31:0] fault_ip,
   output logic [15:0] fault_cs,
   output logic fp_continue,
   output logic shutdown
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic check_enable_bit;
   logic os_vector_fault_support;
   mcx_pkg::mcx_flags_t vfcs_flags;
   mcx_pkg::mcx_flags_t vfcs_masks;
   logic ip_valid_flag;
   logic check_in_prog;
   logic [3:0] err_src;
   logic [15:0] err_code;
   logic [31:0] err_ip;
   logic [15:0] err_cs;
   logic [2:0] pin_enable;
   logic mc_pend;

   logic wr_ctrl4;
   logic wr_vfcs;
   logic wr_gstat;
   logic wr_pinen;
   assign wr_ctrl4 = reg_wr && (reg_addr == `MCX_ADDR_CTRL4);
   assign wr_vfcs = reg_wr && (reg_addr == `MCX_ADDR_VFCS);
   assign wr_gstat = reg_wr && (reg_addr == `MCX_ADDR_GSTAT);
   assign wr_pinen = reg_wr && (reg_addr == `MCX_ADDR_PINEN);

   // ----------------------------------------------------------------
   // Error pin synchronisers
   // ----------------------------------------------------------------
   // Pins come from outside agents; a change counts once stages two
   // and three agree, filtering a single-cycle glitch.
   logic [2:0] pin_s1;
   logic [2:0] pin_s2;
   logic [2:0] pin_s3;
   logic [2:0] pin_lvl;
   logic [2:0] next_pin_lvl;
   logic [2:0] pin_rise;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1 <= 3'h0;
         pin_s2 <= 3'h0;
         pin_s3 <= 3'h0;
      end else begin
         pin_s1 <= ~{bus_check_pin_n, bus_error_report_pin_n,
                     bus_init_error_pin_n};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   assign next_pin_lvl = (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 | pin_s3));
   assign pin_rise = next_pin_lvl & ~pin_lvl & pin_enable;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_lvl <= 3'h0;
      end else begin
         pin_lvl <= next_pin_lvl;
      end
   end

   logic mc_event;
   assign mc_event = int_err_valid || (pin_rise != 3'h0);

   // ----------------------------------------------------------------
   // Packed-fp condition evaluation per sub-operand
   // ----------------------------------------------------------------
   mcx_pkg::mcx_flags_t lane_pre [LANES];
   mcx_pkg::mcx_flags_t lane_post [LANES];
   logic [LANES-1:0] lane_stop;
   logic [LANES-1:0] lane_on;
   mcx_pkg::mcx_flags_t pre_all;
   mcx_pkg::mcx_flags_t post_all;
   mcx_pkg::mcx_flags_t fp_set;
   mcx_pkg::mcx_flags_t fp_unm;

   always_comb begin
      for (int i = 0; i < LANES; i++) begin
         lane_on[i] = fp_quad || (i < 2);
         lane_pre[i] = '0;
         lane_post[i] = '0;
         lane_stop[i] = 1'b0;
         if (fp_signalling_not_a_number[i]) begin
            lane_pre[i][`MCX_FLG_INV] = 1'b1;
            lane_stop[i] = 1'b1;
         end else if (fp_quiet_not_a_number[i]) begin
            lane_stop[i] = 1'b1;
         end else begin
            if (fp_inv_other[i]) begin
               lane_pre[i][`MCX_FLG_INV] = 1'b1;
            end else if (fp_divz[i]) begin
               lane_pre[i][`MCX_FLG_DZ] = 1'b1;
            end
            // Masked priority-3 conditions let the lane go on
            if ((lane_pre[i] & ~vfcs_masks) != '0) begin
               lane_stop[i] = 1'b1;
            end else if (fp_denorm[i]) begin
               lane_pre[i][`MCX_FLG_DEN] = 1'b1;
               lane_stop[i] = !vfcs_masks[`MCX_FLG_DEN];
            end
         end
         if (!lane_stop[i]) begin
            // Post-computation; inexact may join overflow/underflow
            lane_post[i][`MCX_FLG_OVF] = fp_ovf[i];
            lane_post[i][`MCX_FLG_UNF] = fp_unf[i] && !fp_ovf[i];
            lane_post[i][`MCX_FLG_INE] = fp_inex[i];
         end
      end
   end

   always_comb begin
      pre_all = '0;
      post_all = '0;
      for (int i = 0; i < LANES; i++) begin
         if (lane_on[i]) begin
            pre_all = pre_all | lane_pre[i];
            post_all = post_all | lane_post[i];
         end
      end
      // An unmasked pre-computation fault means no arithmetic ran
      if ((pre_all & ~vfcs_masks) != '0) begin
         fp_set = pre_all;
      end else begin
         fp_set = pre_all | post_all;
      end
      fp_unm = fp_set & ~vfcs_masks;
   end

   // ----------------------------------------------------------------
   // Fault selection
   // ----------------------------------------------------------------
   mcx_pkg::mcx_fault_t next_fault;

   always_comb begin
      next_fault = mcx_pkg::mcx_flt_none;
      if (shutdown) begin
         next_fault = mcx_pkg::mcx_flt_none;
      end else if (fp_op_valid && (fp_unm != '0)) begin
         if (os_vector_fault_support) begin
            next_fault = mcx_pkg::mcx_flt_packed;
         end else begin
            next_fault = mcx_pkg::mcx_flt_opcode;
         end
      end else if (mc_pend && !fp_op_valid) begin
         next_fault = mcx_pkg::mcx_flt_check;
      end
   end

   // Only the current instruction's conditions can fault; flags
   // already set in the register are never looked at here.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_valid <= 1'b0;
         fault_vector <= 8'h00;
         fault_abort <= 1'b0;
         fault_push_code <= 1'b0;
         fault_ip <= 32'h0000_0000;
         fault_cs <= 16'h0000;
      end else begin
         fault_valid <= 1'b0;
         fault_push_code <= 1'b0;
         case (next_fault)
            mcx_pkg::mcx_flt_packed: begin
               fault_valid <= 1'b1;
               fault_vector <= `MCX_VEC_PACKED;
               fault_abort <= 1'b0;
               fault_ip <= cur_ip;
               fault_cs <= cur_cs;
            end
            mcx_pkg::mcx_flt_opcode: begin
               fault_valid <= 1'b1;
               fault_vector <= UD_VECTOR;
               fault_abort <= 1'b0;
               fault_ip <= cur_ip;
               fault_cs <= cur_cs;
            end
            mcx_pkg::mcx_flt_check: begin
               fault_valid <= check_enable_bit;
               fault_vector <= `MCX_VEC_CHECK;
               fault_abort <= 1'b1;
               fault_ip <= err_ip;
               fault_cs <= err_cs;
            end
            default: begin
               fault_valid <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fp_continue <= 1'b0;
      end else begin
         fp_continue <= fp_op_valid && (fp_unm == '0) && !shutdown;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         shutdown <= 1'b0;
      end else if (next_fault == mcx_pkg::mcx_flt_check &&
                   !check_enable_bit) begin
         shutdown <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Machine-check capture, then delivery one cycle later
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mc_pend <= 1'b0;
      end else if (mc_event) begin
         mc_pend <= 1'b1;
      end else if (next_fault == mcx_pkg::mcx_flt_check) begin
         mc_pend <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         err_src <= 4'h0;
         err_code <= 16'h0000;
         err_ip <= 32'h0000_0000;
         err_cs <= 16'h0000;
      end else if (mc_event) begin
         err_src <= {pin_rise, int_err_valid};
         err_code <= int_err_valid ? int_err_code : 16'h0000;
         err_ip <= cur_ip;
         err_cs <= cur_cs;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ip_valid_flag <= 1'b0;
      end else if (mc_event) begin
         ip_valid_flag <= cur_ip_related;
      end else if (wr_gstat) begin
         ip_valid_flag <= reg_wdata[`MCX_GSTAT_IPV];
      end
   end

   // Delivery sets in-progress; set wins over a software clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         check_in_prog <= 1'b0;
      end else begin
         check_in_prog <= (wr_gstat ? reg_wdata[`MCX_GSTAT_INPROG]
                                    : check_in_prog) ||
                          (next_fault == mcx_pkg::mcx_flt_check &&
                           check_enable_bit);
      end
   end

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         check_enable_bit <= 1'b0;
         os_vector_fault_support <= 1'b0;
      end else if (wr_ctrl4) begin
         check_enable_bit <= reg_wdata[`MCX_CTRL4_CHKEN];
         os_vector_fault_support <= reg_wdata[`MCX_CTRL4_OSVF];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         vfcs_masks <= `MCX_MASK_RST;
      end else if (wr_vfcs) begin
         vfcs_masks <= reg_wdata[`MCX_VFCS_MASK_LSB +: 6];
      end
   end

   // Sticky; a condition in the write cycle still lands
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         vfcs_flags <= '0;
      end else begin
         vfcs_flags <= (wr_vfcs ? reg_wdata[5:0] : vfcs_flags) |
                       (fp_op_valid && !shutdown ? fp_set : '0);
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_enable <= `MCX_PINEN_RST;
      end else if (wr_pinen) begin
         pin_enable <= reg_wdata[2:0];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (!reg_rd) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_addr == `MCX_ADDR_CTRL4) begin
         reg_rdata <= {30'h0, os_vector_fault_support, check_enable_bit};
      end else if (reg_addr == `MCX_ADDR_VFCS) begin
         reg_rdata <= {20'h0, vfcs_masks, vfcs_flags};
      end else if (reg_addr == `MCX_ADDR_GSTAT) begin
         reg_rdata <= {29'h0, shutdown, check_in_prog, ip_valid_flag};
      end else if (reg_addr == `MCX_ADDR_ERRINFO) begin
         reg_rdata <= {12'h0, err_src, err_code};
      end else if (reg_addr == `MCX_ADDR_ERRIP) begin
         reg_rdata <= err_ip;
      end else if (reg_addr == `MCX_ADDR_PINEN) begin
         reg_rdata <= {29'h0, pin_enable};
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   chk_check_vector: assert property (
      mc_pend && check_enable_bit && !fp_op_valid && !shutdown |=>
         fault_valid && fault_vector == `MCX_VEC_CHECK && fault_abort)
      else $error("machine check not delivered as abort");

   chk_pin_capture: assert property (
      pin_rise != 3'h0 |=> mc_pend && err_src[3:1] == $past(pin_rise))
      else $error("pin error not captured");

   chk_no_code: assert property (
      fault_valid |-> !fault_push_code)
      else $error("error code pushed");

   chk_ip_valid: assert property (
      mc_event |=> ip_valid_flag == $past(cur_ip_related))
      else $error("ip valid flag wrong");

   chk_check_disabled: assert property (
      mc_pend && !check_enable_bit && !fp_op_valid && !shutdown |=>
         shutdown && !fault_valid)
      else $error("disabled check did not shut down");

   chk_packed_cause: assert property (
      fault_valid && fault_vector == `MCX_VEC_PACKED |->
         $past(fp_op_valid) && $past(os_vector_fault_support) &&
         $past(fp_unm) != '0)
      else $error("packed fault without unmasked flag");

   chk_masked_continue: assert property (
      fp_op_valid && fp_unm == '0 && !shutdown |=>
         fp_continue && !(fault_valid && !fault_abort))
      else $error("masked condition faulted");

   chk_opcode_fallback: assert property (
      fp_op_valid && fp_unm != '0 && !os_vector_fault_support &&
         !shutdown |=> fault_valid && fault_vector == UD_VECTOR)
      else $error("missing invalid opcode fallback");

   chk_unmask_quiet: assert property (
      !fp_op_valid && !mc_pend |=> !fault_valid)
      else $error("fault without current cause");

   chk_precise_ip: assert property (
      fp_op_valid && fp_unm != '0 && !shutdown |=>
         fault_valid && fault_ip == $past(cur_ip))
      else $error("packed fault not precise");

   chk_flag_sticky: assert property (
      !wr_vfcs |=> (vfcs_flags & $past(vfcs_flags)) == $past(vfcs_flags))
      else $error("flag lost without software clear");

   chk_quiet_not_a_number_lane0: assert property (
      fp_op_valid && fp_quiet_not_a_number[0] && !fp_signalling_not_a_number[0] |->
         lane_pre[0] == '0 && lane_post[0] == '0)
      else $error("quiet nan lane flagged");

   cov_check_taken: cover property (
      mc_pend && check_enable_bit ##1 fault_valid);
   cov_packed_taken: cover property (
      fault_valid && fault_vector == `MCX_VEC_PACKED);
   cov_shutdown: cover property ($rose(shutdown));
   cov_masked_run: cover property (fp_continue && vfcs_flags != '0);

endmodule : mcx_exc_unit
`default_nettype wire

// ---- common/mcx_consts.svh ----
// Constants for the machine-check and packed-fp exception unit
// Function
// - Machine check delivered as vector 18, abort.
// - Enabled error pin captures info, then faults.
// - Machine check pushes no error code.
// - IP-valid flag set only when pointer related.
// - Machine check enabled only by enable bit.
// - Disabled machine check enters shutdown instead.
// - Vector 19 needs set flag and unmask.
// - Six conditions, each with flag and mask.
// - Pre-computation then post-computation condition detection.
// - Masked condition gives default result, continues.
// - Unmasked without OS support gives invalid opcode.
// - Unmasked faults precise, on faulting instruction.
// - Unmasking a set flag raises nothing.
// - Every sub-operand's pre-computation conditions are flagged; post ones only without an unmasked pre.
// - One condition per sub-operand, by priority.
// - Quiet NaN operand dominates, flags nothing.
// - Masked priority 3-5 continues to lower.
// - Packed-fp fault pushes no code, own IP.
`ifndef MCX_CONSTS_SVH
`define MCX_CONSTS_SVH
// ----------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------
`define MCX_ADDR_CTRL4 4'h0
`define MCX_ADDR_VFCS 4'h1
`define MCX_ADDR_GSTAT 4'h2
`define MCX_ADDR_ERRINFO 4'h3
`define MCX_ADDR_ERRIP 4'h4
`define MCX_ADDR_PINEN 4'h5
// ----------------------------------------------------------------
// Fields, vectors, reset values
// ----------------------------------------------------------------
`define MCX_CTRL4_CHKEN 0
`define MCX_CTRL4_OSVF 1
`define MCX_FLG_INV 0
`define MCX_FLG_DZ 1
`define MCX_FLG_DEN 2
`define MCX_FLG_OVF 3
`define MCX_FLG_UNF 4
`define MCX_FLG_INE 5
`define MCX_VFCS_MASK_LSB 6
`define MCX_GSTAT_IPV 0
`define MCX_GSTAT_INPROG 1
`define MCX_VEC_CHECK 8'h12
`define MCX_VEC_PACKED 8'h13
`define MCX_MASK_RST 6'h3F
`define MCX_PINEN_RST 3'h7
`endif

// ---- common/mcx_pkg.sv ----
// Types shared by the exception unit
`default_nettype none
package mcx_pkg;
   typedef logic [5:0] mcx_flags_t;
   typedef enum logic [1:0] {
      mcx_flt_none,
      mcx_flt_check,
      mcx_flt_packed,
      mcx_flt_opcode
   } mcx_fault_t;
endpackage : mcx_pkg
`default_nettype wire

// ---- test/mcx_bus_agent.sv ----
// Outside bus agent that reports bus errors on the three error pins
`default_nettype none
module mcx_bus_agent (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [2:0] fire,
   output logic [2:0] pin_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] cnt [3];
   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   // Idle high as with a pull-up; held low five cycles so the
   // three-flop synchroniser inside the core sees the level
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_n <= 3'h7;
         for (int i = 0; i < 3; i++) begin
            cnt[i] <= 3'h0;
         end
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (fire[i]) begin
               cnt[i] <= 3'h5;
            end else if (cnt[i] != 3'h0) begin
               cnt[i] <= cnt[i] - 3'h1;
            end
            pin_n[i] <= !(fire[i] || cnt[i] > 3'h1);
         end
      end
   end
endmodule : mcx_bus_agent
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the machine-check and packed-fp unit
`include "mcx_consts.svh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] UD_VEC = 8'h06;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic int_err_valid = 1'b0;
   logic [15:0] int_err_code = 16'h0;
   logic [31:0] cur_ip = 32'h0;
   logic [15:0] cur_cs = 16'h0;
   logic cur_ip_related = 1'b0;
   logic fp_op_valid = 1'b0;
   logic fp_quad = 1'b0;
   logic [2:0] fire = 3'h0;
   logic [3:0] fp_signalling_not_a_number, fp_quiet_not_a_number, fp_inv_other, fp_divz;
   logic [3:0] fp_denorm, fp_ovf, fp_unf, fp_inex;
   logic [31:0] reg_rdata, fault_ip, last_ip;
   logic [15:0] fault_cs;
   logic [7:0] fault_vector;
   logic [2:0] pin_n;
   logic fault_valid, fault_abort, fault_push_code, fp_continue, shutdown;
   logic [31:0] seed = 32'h50ED;
   logic [5:0] flags, mask;
   logic os;
   int fail_count = 0;
   int checked = 0;
   int cycles = 0;

   mcx_exc_unit #(.LANES(4), .UD_VECTOR(UD_VEC)) i_mcx_exc_unit (
      .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .bus_init_error_pin_n(pin_n[0]),
      .bus_error_report_pin_n(pin_n[1]), .bus_check_pin_n(pin_n[2]),
      .int_err_valid(int_err_valid), .int_err_code(int_err_code),
      .cur_ip(cur_ip), .cur_cs(cur_cs), .cur_ip_related(cur_ip_related),
      .fp_op_valid(fp_op_valid), .fp_quad(fp_quad), .fp_signalling_not_a_number(fp_signalling_not_a_number),
      .fp_quiet_not_a_number(fp_quiet_not_a_number), .fp_inv_other(fp_inv_other), .fp_divz(fp_divz),
      .fp_denorm(fp_denorm), .fp_ovf(fp_ovf), .fp_unf(fp_unf),
      .fp_inex(fp_inex), .fault_valid(fault_valid),
      .fault_vector(fault_vector), .fault_abort(fault_abort),
      .fault_push_code(fault_push_code), .fault_ip(fault_ip),
      .fault_cs(fault_cs), .fp_continue(fp_continue), .shutdown(shutdown)
   );
   mcx_bus_agent i_mcx_bus_agent (
      .core_clk(core_clk), .rst_n(rst_n), .fire(fire), .pin_n(pin_n)
   );

   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 10000) begin
         fail_count++;
         close_out();
      end
   end
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // Lane bits: 0 signalling_not_a_number 1 quiet_not_a_number 2 inv 3 divz 4 den 5 ovf 6 unf 7 inex
   function automatic logic [5:0] fp_exp(input logic [3:0][7:0] c,
         input logic q, input logic [5:0] m);
      logic [5:0] f;
      logic [5:0] l;
      f = 6'h00;
      for (int i = 0; i < (q ? 4 : 2); i++) begin
         l = 6'h00;
         if (c[i][0]) begin
            l[0] = 1'b1;
         end else if (!c[i][1]) begin
            if (c[i][2]) l[0] = 1'b1;
            else if (c[i][3]) l[1] = 1'b1;
            if (c[i][4]) l[2] = 1'b1;
            if ((l[2:0] & ~m[2:0]) == 3'h0) begin
               if (c[i][5]) l[3] = 1'b1;
               else if (c[i][6]) l[4] = 1'b1;
               if (c[i][7]) l[5] = 1'b1;
            end
         end
         f = f | l;
      end
      // Unmasked pre-computation fault: no arithmetic ran in any lane
      if ((f[2:0] & ~m[2:0]) != 3'h0) f[5:3] = 3'h0;
      return f;
   endfunction : fp_exp
   task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_v
   task automatic chk_flt(input logic [7:0] v, input logic [31:0] ip,
         input logic with_ip);
      chk_v(32'({fault_valid, fault_push_code}), 32'h2);
      chk_v(32'({fault_vector, fault_abort}),
            32'({v, v == `MCX_VEC_CHECK}));
      if (with_ip) chk_v({fault_cs, fault_ip[15:0]}, ip);
      if (with_ip) chk_v(fault_ip, ip);
   endtask : chk_flt
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      chk_v(d, exp);
   endtask : rchk
   // Bounded wait for a delivered fault or shutdown
   task automatic wait_evt(input int lim, output int k);
      k = 0;
      do begin
         @(posedge core_clk);
         #1 k++;
      end while (!(fault_valid === 1'b1 || shutdown === 1'b1) && k < lim);
   endtask : wait_evt
   task automatic mc_int(input logic rel, output int k);
      last_ip = rnd();
      @(posedge core_clk);
      int_err_valid <= 1'b1;
      int_err_code <= last_ip[15:0];
      cur_ip <= last_ip;
      cur_cs <= last_ip[31:16];
      cur_ip_related <= rel;
      @(posedge core_clk);
      int_err_valid <= 1'b0;
      wait_evt(20, k);
   endtask : mc_int
   task automatic fp_op(input logic [3:0][7:0] c, input logic q);
      logic [5:0] nf;
      logic [31:0] ip;
      nf = fp_exp(c, q, mask);
      ip = rnd();
      @(posedge core_clk);
      fp_op_valid <= 1'b1;
      fp_quad <= q;
      cur_ip <= ip;
      cur_cs <= ip[31:16];
      for (int i = 0; i < 4; i++) begin
         fp_signalling_not_a_number[i] <= c[i][0];
         fp_quiet_not_a_number[i] <= c[i][1];
         fp_inv_other[i] <= c[i][2];
         fp_divz[i] <= c[i][3];
         fp_denorm[i] <= c[i][4];
         fp_ovf[i] <= c[i][5];
         fp_unf[i] <= c[i][6];
         fp_inex[i] <= c[i][7];
      end
      @(posedge core_clk);
      fp_op_valid <= 1'b0;
      #1 flags = flags | nf;
      chk_v(32'({fault_valid, fp_continue}),
            (nf & ~mask) != 6'h00 ? 32'h2 : 32'h1);
      if ((nf & ~mask) != 6'h00) begin
         chk_flt(os ? `MCX_VEC_PACKED : UD_VEC, ip, 1'b1);
      end
   endtask : fp_op
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      flags = 6'h00;
      mask = 6'h3F;
      os = 1'b0;
   endtask : do_reset
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      int k;
      logic [31:0] d;
      logic [31:0] r;
      logic [3:0][7:0] c;
      {fp_signalling_not_a_number, fp_quiet_not_a_number, fp_inv_other, fp_divz} = 16'h0000;
      {fp_denorm, fp_ovf, fp_unf, fp_inex} = 16'h0000;
      do_reset();
      rchk(4'h1, 32'h00000FC0);
      rchk(4'h5, 32'h00000007);
      wr(4'hF, 32'hFFFFFFFF);
      rchk(4'h0, 32'h00000000);
      rchk(4'hF, 32'h00000000);
      mc_int(1'b0, k);
      chk_v(32'(k), 32'h1);
      chk_v(32'({fault_valid, shutdown}), 32'h1);
      rchk(4'h2, 32'h00000004);
      do_reset();
      #1 chk_v(32'(shutdown), 32'h0);
      wr(4'h0, 32'h00000003);
      os = 1'b1;
      mc_int(1'b1, k);
      chk_v(32'(k), 32'h1);
      chk_flt(`MCX_VEC_CHECK, last_ip, 1'b1);
      rchk(4'h3, {15'h0, 1'b1, last_ip[15:0]});
      rchk(4'h4, last_ip);
      rchk(4'h2, 32'h00000003);
      wr(4'h2, 32'h00000000);
      mc_int(1'b0, k);
      chk_flt(`MCX_VEC_CHECK, 32'h0, 1'b0);
      rchk(4'h2, 32'h00000002);
      for (int i = 0; i < 3; i++) begin
         @(posedge core_clk);
         fire <= 3'(1 << i);
         @(posedge core_clk);
         fire <= 3'h0;
         wait_evt(20, k);
         chk_flt(`MCX_VEC_CHECK, 32'h0, 1'b0);
         rd(4'h3, d);
         chk_v(32'(d[17 + i]), 32'h1);
      end
      wr(4'h5, 32'h00000000);
      fire <= 3'h2;
      @(posedge core_clk);
      fire <= 3'h0;
      wait_evt(20, k);
      chk_v(32'(fault_valid), 32'h0);
      wr(4'h5, 32'h00000007);
      // Flags picked up under mask must stay silent when unmasked
      fp_op(32'hFFFFFFFF & 32'h24242424, 1'b1);
      wr(4'h1, {20'h0, 6'h00, flags});
      mask = 6'h00;
      wait_evt(6, k);
      chk_v(32'({fault_valid, 8'(k)}), 32'h6);
      for (int n = 0; n < 300; n++) begin
         if (n % 8 == 0) begin
            r = rnd();
            os = r[0];
            mask = r[6:1];
            if (n % 16 == 0) flags = 6'h00;
            wr(4'h0, {30'h0, os, 1'b1});
            wr(4'h1, {20'h0, mask, flags});
         end
         for (int i = 0; i < 4; i++) begin
            c[i] = 8'(rnd() & rnd());
            if (c[i][2] | c[i][3]) c[i][4] = 1'b0;
            if (c[i][5] | c[i][6]) c[i][7] = 1'b0;
         end
         r = rnd();
         fp_op(c, r[0]);
         rchk(4'h1, {20'h0, mask, flags});
      end
      close_out();
   end
endmodule : tb
`default_nettype wire
